// ### src/rtcs_port.sv
module rtcs_port (
    // system clock domain
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         ce,
    // link clock domain
    input  wire logic                         link_clk,
    // two-wire pins
    input  wire logic                         scl_i,
    input  wire logic                         sda_i,
    output logic                              sda_o,
    output logic                              sda_oe,
    // timekeeping side write port
    input  wire logic                         core_we,
    input  wire logic [rtcs_pkg::PTR_W-1:0]   core_addr,
    input  wire logic [rtcs_pkg::BYTE_W-1:0]  core_wdata,
    // timekeeping side read port
    input  wire logic [rtcs_pkg::PTR_W-1:0]   core_raddr,
    output logic      [rtcs_pkg::BYTE_W-1:0]  core_rdata,
    // notice of bytes written by the master
    output logic                              bus_wr,
    output logic      [rtcs_pkg::PTR_W-1:0]   bus_wr_addr,
    output logic      [rtcs_pkg::BYTE_W-1:0]  bus_wr_data
);
    import rtcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // link domain signals

    logic                 l_scl;
    logic                 l_sda;
    logic                 ce_l;
    logic                 l_rep;
    logic                 p_scl;
    logic                 p_sda;
    logic                 start_c;
    logic                 stop_c;
    logic                 rise_c;
    logic                 fall_c;
    rtcs_state_t          state;
    logic [CNT_W-1:0]     bitcnt;
    logic [BYTE_W-1:0]    shreg;
    logic [BYTE_W-1:0]    tx;
    logic [PTR_W-1:0]     ptr;
    logic                 rd_mode;
    logic                 wr_data_ack;
    logic                 req_tog;
    logic                 req_wr;
    logic [PTR_W-1:0]     req_addr;
    logic [BYTE_W-1:0]    req_data;
    logic                 rep_seen;
    logic                 rep_new;

    // system domain signals
    logic                 req_s;
    logic                 req_prev;
    logic                 req_new;
    logic                 rep_tog;
    logic [BYTE_W-1:0]    rep_data;
    logic [BYTE_W-1:0]    mem [NUM_REGS];

    ////////////////////////////////////////////////////////////////////////
    // crossings into each domain

    rtcs_sync #(.W(4)) u_sync_link (
        .clk (link_clk),
        .rst (rst),
        .d   ({scl_i, sda_i, ce, rep_tog}),
        .q   ({l_scl, l_sda, ce_l, l_rep})
    );

    rtcs_sync #(.W(1)) u_sync_sys (
        .clk (clk),
        .rst (rst),
        .d   (req_tog),
        .q   (req_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // line history and bus conditions

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            p_scl <= 1'b1;
            p_sda <= 1'b1;
        end else if (ce_l) begin
            p_scl <= l_scl;
            p_sda <= l_sda;
        end
    end

    // data moving while clock stays high is a control condition
    assign start_c = p_scl & l_scl & p_sda & ~l_sda;
    assign stop_c  = p_scl & l_scl & ~p_sda & l_sda;
    assign rise_c  = ~p_scl & l_scl;
    assign fall_c  = p_scl & ~l_scl;
    assign rep_new = l_rep != rep_seen;

    // open drain: only ever pulls low
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            sda_o <= LINE_LOW;
        end else begin
            sda_o <= LINE_LOW;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protocol engine

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            state       <= ST_IDLE;
            bitcnt      <= CNT_ZERO;
            shreg       <= BYTE_ZERO;
            tx          <= BYTE_ZERO;
            sda_oe      <= 1'b0;
            ptr         <= PTR_RST;
            rd_mode     <= 1'b0;
            wr_data_ack <= 1'b0;
            req_tog     <= 1'b0;
            req_wr      <= 1'b0;
            req_addr    <= PTR_RST;
            req_data    <= BYTE_ZERO;
            rep_seen    <= 1'b0;
        end else if (ce_l) begin
            // fetched byte lands while the bus is in an ack bit
            if (rep_new) begin
                tx       <= rep_data;
                rep_seen <= l_rep;
            end
            if (start_c) begin
                state  <= ST_ADDR;
                bitcnt <= CNT_ZERO;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    ST_ADDR, ST_WPTR, ST_WDATA: begin
                        if (rise_c) begin
                            shreg  <= {shreg[MSB-1:0], l_sda};
                            bitcnt <= bitcnt + CNT_ONE;
                        end else if (fall_c && bitcnt == BITS_PER_BYTE) begin
                            bitcnt <= CNT_ZERO;
                            if (state == ST_ADDR) begin
                                if (shreg[ADDR_HI:ADDR_LO] == SLAVE_ADDR[ADDR_HI:ADDR_LO]) begin
                                    sda_oe      <= 1'b1;
                                    state       <= ST_ACK_ADDR;
                                    rd_mode     <= shreg[DIR_BIT];
                                    wr_data_ack <= 1'b0;
                                    if (shreg[DIR_BIT]) begin
                                        // fetch from the pointer as it stands
                                        req_tog  <= ~req_tog;
                                        req_wr   <= 1'b0;
                                        req_addr <= ptr;
                                    end
                                end else begin
                                    state <= ST_IGNORE;
                                end
                            end else if (state == ST_WPTR) begin
                                ptr         <= shreg[PTR_W-1:0];
                                sda_oe      <= 1'b1;
                                state       <= ST_ACK_W;
                                wr_data_ack <= 1'b0;
                            end else begin
                                req_tog     <= ~req_tog;
                                req_wr      <= 1'b1;
                                req_addr    <= ptr;
                                req_data    <= shreg;
                                sda_oe      <= 1'b1;
                                state       <= ST_ACK_W;
                                wr_data_ack <= 1'b1;
                            end
                        end
                    end
                    ST_ACK_ADDR: begin
                        if (fall_c) begin
                            if (rd_mode) begin
                                sda_oe <= ~tx[MSB];
                                tx     <= {tx[MSB-1:0], 1'b0};
                                bitcnt <= CNT_ONE;
                                state  <= ST_TX;
                            end else begin
                                sda_oe <= 1'b0;
                                state  <= ST_WPTR;
                            end
                        end
                    end
                    ST_ACK_W: begin
                        // ack held until the falling edge ends the ninth pulse
                        if (fall_c) begin
                            sda_oe <= 1'b0;
                            state  <= ST_WDATA;
                            if (wr_data_ack) begin
                                ptr <= ptr + PTR_ONE;
                            end
                        end
                    end
                    ST_TX: begin
                        if (fall_c) begin
                            if (bitcnt == BITS_PER_BYTE) begin
                                sda_oe <= 1'b0;
                                state  <= ST_MACK;
                            end else begin
                                sda_oe <= ~tx[MSB];
                                tx     <= {tx[MSB-1:0], 1'b0};
                                bitcnt <= bitcnt + CNT_ONE;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (rise_c) begin
                            if (l_sda == LINE_LOW) begin
                                ptr      <= ptr + PTR_ONE;
                                req_tog  <= ~req_tog;
                                req_wr   <= 1'b0;
                                req_addr <= ptr + PTR_ONE;
                            end else begin
                                state <= ST_IGNORE;
                            end
                        end else if (fall_c) begin
                            sda_oe <= ~tx[MSB];
                            tx     <= {tx[MSB-1:0], 1'b0};
                            bitcnt <= CNT_ONE;
                            state  <= ST_TX;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system side: byte store and request service

    // request fields are held steady by the link side for a whole byte
    assign req_new = req_s != req_prev;

    always_ff @(posedge clk) begin
        if (ce) begin
            if (req_new && req_wr) begin
                mem[req_addr] <= req_data;
            end else if (core_we) begin
                mem[core_addr] <= core_wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_prev    <= 1'b0;
            rep_tog     <= 1'b0;
            rep_data    <= BYTE_ZERO;
            bus_wr      <= 1'b0;
            bus_wr_addr <= PTR_RST;
            bus_wr_data <= BYTE_ZERO;
            core_rdata  <= BYTE_ZERO;
        end else if (ce) begin
            req_prev   <= req_s;
            bus_wr     <= 1'b0;
            core_rdata <= mem[core_raddr];
            if (req_new) begin
                if (req_wr) begin
                    bus_wr      <= 1'b1;
                    bus_wr_addr <= req_addr;
                    bus_wr_data <= req_data;
                end else begin
                    rep_data <= mem[req_addr];
                    rep_tog  <= ~rep_tog;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_data_byte_done;
        ce_l && state == ST_WDATA && fall_c && bitcnt == BITS_PER_BYTE;
    endsequence

    sequence s_master_nack;
        ce_l && state == ST_MACK && rise_c && l_sda;
    endsequence

    chk_start_to_addr: assert property (@(posedge link_clk) disable iff (rst)
        ce_l && start_c |=> state == ST_ADDR && !sda_oe)
        else $error("start did not open address phase");

    chk_stop_to_idle: assert property (@(posedge link_clk) disable iff (rst)
        ce_l && stop_c |=> state == ST_IDLE && !sda_oe)
        else $error("stop did not return to idle");

    chk_mismatch_quiet: assert property (@(posedge link_clk) disable iff (rst)
        state == ST_IGNORE |-> !sda_oe)
        else $error("line driven while not addressed");

    chk_addr_reject: assert property (@(posedge link_clk) disable iff (rst)
        ce_l && state == ST_ADDR && fall_c && bitcnt == BITS_PER_BYTE
        && shreg[ADDR_HI:ADDR_LO] != SLAVE_ADDR[ADDR_HI:ADDR_LO] |=> state == ST_IGNORE)
        else $error("foreign address not ignored");

    chk_oe_scl_low: assert property (@(posedge link_clk) disable iff (rst)
        $changed(sda_oe) |-> !$past(l_scl))
        else $error("data line changed while clock high");

    chk_data_ack: assert property (@(posedge link_clk) disable iff (rst)
        s_data_byte_done |=> sda_oe && state == ST_ACK_W)
        else $error("received byte not acknowledged");

    chk_ptr_step: assert property (@(posedge link_clk) disable iff (rst)
        ce_l && state == ST_ACK_W && fall_c && wr_data_ack |=> ptr == $past(ptr) + PTR_ONE)
        else $error("pointer did not advance after write");

    chk_nack_release: assert property (@(posedge link_clk) disable iff (rst)
        s_master_nack |=> state == ST_IGNORE ##1 !sda_oe)
        else $error("line not released after master nack");

    chk_ack_hold: assert property (@(posedge link_clk) disable iff (rst)
        state == ST_ACK_W && l_scl |-> sda_oe)
        else $error("ack released during clock high");

    chk_write_lands: assert property (@(posedge clk) disable iff (rst)
        ce && req_new && req_wr |=> bus_wr && bus_wr_addr == $past(req_addr))
        else $error("master write not posted");

endmodule : rtcs_port

// ### src/rtcs_pkg.sv
package rtcs_pkg;

    localparam int         BYTE_W        = 8;
    localparam int         PTR_W         = 3;
    localparam int         CNT_W         = 4;
    localparam int         NUM_REGS      = 8;
    localparam int         MSB           = 7;
    localparam int         ADDR_HI       = 7;
    localparam int         ADDR_LO       = 1;
    localparam int         DIR_BIT       = 0;

    localparam logic [7:0] SLAVE_ADDR    = 8'hD0;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    localparam logic [3:0] CNT_ZERO      = 4'h0;
    localparam logic [3:0] CNT_ONE       = 4'h1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] PTR_RST       = 3'h0;
    localparam logic [2:0] PTR_ONE       = 3'h1;
    localparam logic       LINE_LOW      = 1'h0;

    // byte locations in pointer order
    localparam logic [2:0] REG_SECONDS   = 3'h0;
    localparam logic [2:0] REG_MINUTES   = 3'h1;
    localparam logic [2:0] REG_CENT_HRS  = 3'h2;
    localparam logic [2:0] REG_DAY       = 3'h3;
    localparam logic [2:0] REG_DATE      = 3'h4;
    localparam logic [2:0] REG_MONTH     = 3'h5;
    localparam logic [2:0] REG_YEARS     = 3'h6;
    localparam logic [2:0] REG_CONTROL   = 3'h7;

    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_ADDR     = 9'h002,
        ST_ACK_ADDR = 9'h004,
        ST_WPTR     = 9'h008,
        ST_ACK_W    = 9'h010,
        ST_WDATA    = 9'h020,
        ST_TX       = 9'h040,
        ST_MACK     = 9'h080,
        ST_IGNORE   = 9'h100
    } rtcs_state_t;

endpackage : rtcs_pkg

// ### src/rtcs_sync.sv
module rtcs_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // meta is read by q only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : rtcs_sync

// ### dv/rtcs_bus_master.sv
module rtcs_bus_master (
    // system clock
    input  wire logic clk,
    // two-wire lines
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low,
    // set when data moved while clock high
    output logic      glitch
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl     = 1'h1;
        sda_low = 1'h0;
        glitch  = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // wait well past the device's answer delay before touching data
    task automatic bit_xfer(input logic drive, output logic seen);
        logic early;
        scl <= 1'h0;
        repeat (60) @(posedge clk);
        sda_low <= ~drive;
        repeat (90) @(posedge clk);
        scl <= 1'h1;
        repeat (10) @(posedge clk);
        early = sda;
        repeat (114) @(posedge clk);
        seen = sda;
        if (early !== seen) glitch <= 1'h1;
        @(posedge clk);
    endtask : bit_xfer

    task automatic start_cond();
        scl <= 1'h0;
        repeat (60) @(posedge clk);
        sda_low <= 1'h0;
        repeat (90) @(posedge clk);
        scl <= 1'h1;
        repeat (60) @(posedge clk);
        sda_low <= 1'h1;
        repeat (60) @(posedge clk);
    endtask : start_cond

    task automatic stop_cond();
        scl <= 1'h0;
        repeat (60) @(posedge clk);
        sda_low <= 1'h1;
        repeat (90) @(posedge clk);
        scl <= 1'h1;
        repeat (60) @(posedge clk);
        sda_low <= 1'h0;
        repeat (130) @(posedge clk);
    endtask : stop_cond

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
        bit_xfer(1'h1, s);
        ack = ~s;
    endtask : put_byte

    task automatic get_byte(input logic give_ack, output logic [7:0] b, output logic line);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'h1, s);
            b[i] = s;
        end
        bit_xfer(~give_ack, line);
    endtask : get_byte
endmodule : rtcs_bus_master

// ### dv/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import rtcs_pkg::*;

    logic              clk, rst, ce, link_clk, scl, m_low, glitch;
    logic              sda_o, sda_oe, core_we, bus_wr;
    logic [PTR_W-1:0]  core_addr, core_raddr, bus_wr_addr;
    logic [BYTE_W-1:0] core_wdata, core_rdata, bus_wr_data;
    wire logic         sda;
    int                errors, total_checks, ptr;
    int                mem [NUM_REGS];
    logic [31:0]       lfsr;
    logic [10:0]       wr_q [$];
    logic [7:0]        bad [3] = '{8'hA0, 8'hD2, 8'h50};

    // open drain with pull-up
    assign sda = (sda_oe ? sda_o : 1'h1) & ~m_low;

    rtcs_port i_rtcs_port (.clk(clk), .rst(rst), .ce(ce), .link_clk(link_clk), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .core_we(core_we), .core_addr(core_addr),
        .core_wdata(core_wdata), .core_raddr(core_raddr), .core_rdata(core_rdata),
        .bus_wr(bus_wr), .bus_wr_addr(bus_wr_addr), .bus_wr_data(bus_wr_data));

    rtcs_bus_master i_rtcs_bus_master (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low),
        .glitch(glitch));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // phase unrelated to clk
    initial begin
        link_clk = 1'h0;
        #37;
        forever #62.5 link_clk = ~link_clk;
    end

    always @(posedge clk) if (bus_wr === 1'h1) wr_q.push_back({bus_wr_addr, bus_wr_data});

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic core_write(input int a, input logic [7:0] d);
        @(posedge clk);
        core_we    <= 1'h1;
        core_addr  <= a[2:0];
        core_wdata <= d;
        mem[a] = d;
        @(posedge clk);
        core_we <= 1'h0;
    endtask : core_write

    task automatic bus_write(input int p, input int n);
        logic        ack;
        logic [7:0]  d;
        logic [10:0] w;
        i_rtcs_bus_master.start_cond();
        i_rtcs_bus_master.put_byte(SLAVE_ADDR, ack);
        check("addr ack", ack, 1);
        i_rtcs_bus_master.put_byte(8'(p), ack);
        check("ptr ack", ack, 1);
        ptr = p;
        for (int i = 0; i < n; i++) begin
            d = lfsr[7:0];
            lfsr = lfsr_next(lfsr);
            i_rtcs_bus_master.put_byte(d, ack);
            check("data ack", ack, 1);
            w = (wr_q.size() > 0) ? wr_q.pop_front() : 'x;
            check("write addr", w[10:8], ptr);
            check("write data", w[7:0], d);
            mem[ptr] = d;
            ptr = (ptr + 1) % NUM_REGS;
        end
        i_rtcs_bus_master.stop_cond();
    endtask : bus_write

    task automatic bus_read(input int n, input logic wp, input int p);
        logic       ack, line;
        logic [7:0] b;
        i_rtcs_bus_master.start_cond();
        if (wp) begin
            i_rtcs_bus_master.put_byte(SLAVE_ADDR, ack);
            check("addr ack", ack, 1);
            i_rtcs_bus_master.put_byte(8'(p), ack);
            check("ptr ack", ack, 1);
            ptr = p;
            i_rtcs_bus_master.start_cond();
        end
        i_rtcs_bus_master.put_byte(SLAVE_ADDR | 8'h01, ack);
        check("read addr ack", ack, 1);
        for (int i = 0; i < n; i++) begin
            i_rtcs_bus_master.get_byte(i < n - 1, b, line);
            check("read data", b, mem[ptr]);
            if (i < n - 1) ptr = (ptr + 1) % NUM_REGS;
        end
        check("release after nack", line, 1);
        i_rtcs_bus_master.stop_cond();
    endtask : bus_read

    ////////////////////////////////////////////////////////////////////////
    // traffic takes about 73k clk cycles; margin on top, still under 100k
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    initial begin
        logic ack;
        rst = 1'h0;
        ce = 1'h1;
        core_we = 1'h0;
        core_addr = 3'h0;
        core_wdata = 8'h00;
        core_raddr = 3'h0;
        lfsr = 32'h00015EC7;
        // a real rising edge, so both domains take the async reset
        @(posedge clk) rst <= 1'h1;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        // first start well after the link side leaves reset
        repeat (4) @(posedge link_clk);
        for (int a = 0; a < NUM_REGS; a++) begin
            core_write(a, lfsr[7:0]);
            lfsr = lfsr_next(lfsr);
        end
        foreach (bad[k]) begin
            i_rtcs_bus_master.start_cond();
            i_rtcs_bus_master.put_byte(bad[k], ack);
            check("foreign addr nack", ack, 0);
        end
        i_rtcs_bus_master.put_byte(SLAVE_ADDR, ack);
        check("ignored until start", ack, 0);
        i_rtcs_bus_master.stop_cond();
        bus_write(6, 3);
        bus_read(3, 1'h1, 2);
        bus_read(2, 1'h0, 0);
        bus_read(9, 1'h0, 0);
        for (int a = 0; a < NUM_REGS; a++) begin
            @(posedge clk) core_raddr <= a[2:0];
            repeat (2) @(posedge clk);
            check("stored byte", core_rdata, mem[a]);
        end
        // read register must hold while ce is low
        @(posedge clk) ce <= 1'h0;
        core_raddr <= 3'h0;
        repeat (3) @(posedge clk);
        check("frozen by ce", core_rdata, mem[NUM_REGS - 1]);
        ce <= 1'h1;
        check("data stable in clock high", glitch, 0);
        report_and_stop();
    end
endmodule : tb_top
